// ### rtl/slp_pkg.sv
/*
  Shared constants for the SDRAM controller local user port: timing counts,
  request buffering limits, default geometry and the self-refresh states.
  Assumes a single 40 MHz user clock supplied by the PHY.
*/
package slp_pkg;

  localparam int unsigned CLK_MHZ        = 40;
  // Auto-refresh interval in ns; the cycle count is rounded down
  localparam int unsigned T_REFI_NS      = 7800;
  localparam int unsigned REFI_CYC       = (T_REFI_NS * CLK_MHZ) / 1000;
  localparam int unsigned REFI_W         = 16;
  localparam int unsigned MAX_BURST_LIM  = 64;
  localparam int unsigned REQ_SLOTS      = 8;
  localparam int unsigned FIFO_WORDS     = 16;
  localparam int unsigned DEF_ROW_BITS   = 13;
  localparam int unsigned DEF_BANK_BITS  = 2;
  localparam int unsigned DEF_COL_BITS   = 10;
  localparam int unsigned DEF_DQ_W       = 16;
  localparam int unsigned DEF_MAX_BURST  = 64;
  localparam int unsigned DEF_RATE       = 1;

  // Self-refresh sequencer, one-hot
  typedef enum logic [3:0] {
    SR_IDLE  = 4'h1,
    SR_ENTER = 4'h2,
    SR_IN    = 4'h4,
    SR_EXIT  = 4'h8
  } slp_sr_state_t;

  // Largest power of two not above v
  function automatic int unsigned pow2_floor(input int unsigned v);
    int unsigned p;
    p = 1;
    while ((p * 2) <= v)
      p = p * 2;
    return p;
  endfunction : pow2_floor

endpackage : slp_pkg

// ### rtl/slp_local_port.sv
/*
  Local user port of a soft SDRAM controller: request buffering, address
  split into chip/row/bank/column, byte-mask to data-mask conversion,
  refresh and self-refresh control, read return and init-done reporting.
  Assumes the memory-side scheduler and PHY share core_clk with the user.
*/
`timescale 1ns/1ps
`default_nettype none

module slp_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if ((DEPTH < 2) || ((1 << PW) != DEPTH))
  begin : g_bad_depth
    $error("slp_fifo depth must be a power of two");
  end

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage has no reset; only pointers and count carry control state
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : slp_fifo

module slp_local_port #(
  parameter int unsigned RATE      = slp_pkg::DEF_RATE,
  parameter int unsigned NUM_CS    = 1,
  parameter int unsigned ROW_BITS  = slp_pkg::DEF_ROW_BITS,
  parameter int unsigned BANK_BITS = slp_pkg::DEF_BANK_BITS,
  parameter int unsigned COL_BITS  = slp_pkg::DEF_COL_BITS,
  parameter int unsigned DQ_W      = slp_pkg::DEF_DQ_W,
  parameter int unsigned MAX_BURST = slp_pkg::DEF_MAX_BURST,
  parameter bit          POW2_BUS  = 1'b0,
  parameter bit          USER_RFSH = 1'b1,
  parameter int unsigned CHIP_BITS = (NUM_CS > 1) ? $clog2(NUM_CS) : 0,
  parameter int unsigned COL_LSB   = $clog2(RATE) + 1,
  parameter int unsigned ADDR_W    = CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS - COL_LSB,
  parameter int unsigned SIZE_W    = $clog2(MAX_BURST + 1),
  parameter int unsigned DW        = POW2_BUS ? slp_pkg::pow2_floor(DQ_W * 2 * RATE) : DQ_W * 2 * RATE,
  parameter int unsigned MW        = DW / 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic [ADDR_W-1:0]    local_addr,
  input  wire logic [SIZE_W-1:0]    local_size,
  input  wire logic                 local_burst_begin,
  input  wire logic                 local_write_req,
  input  wire logic                 local_read_req,
  input  wire logic [DW-1:0]        local_wdata,
  input  wire logic [MW-1:0]        local_byte_mask,
  input  wire logic                 local_autopch_req,
  input  wire logic                 local_refresh_req,
  input  wire logic [NUM_CS-1:0]    local_refresh_chip,
  input  wire logic                 local_self_rfsh_req,
  input  wire logic [NUM_CS-1:0]    local_self_rfsh_chip,
  output logic                      local_ready,
  output logic [DW-1:0]             local_rdata,
  output logic                      local_rdata_valid,
  output logic                      local_refresh_ack,
  output logic                      local_self_rfsh_ack,
  output logic                      local_init_done,
  input  wire logic                 usr_mode_rdy,
  input  wire logic                 mem_cmd_ready,
  output logic                      mem_cmd_valid,
  output logic                      mem_cmd_first,
  output logic                      mem_cmd_write,
  output logic                      mem_cmd_autopch,
  output logic [NUM_CS-1:0]         mem_cmd_chip,
  output logic [ROW_BITS-1:0]       mem_cmd_row,
  output logic [BANK_BITS-1:0]      mem_cmd_bank,
  output logic [COL_BITS-1:0]       mem_cmd_col,
  output logic [SIZE_W-1:0]         mem_cmd_size,
  output logic [DW-1:0]             mem_wr_data,
  output logic [MW-1:0]             memory_data_mask,
  output logic                      mem_refresh_valid,
  output logic [NUM_CS-1:0]         mem_refresh_chip,
  input  wire logic                 mem_sr_ok,
  input  wire logic                 mem_sr_exit_done,
  output logic                      mem_self_rfsh,
  output logic [NUM_CS-1:0]         mem_self_rfsh_chip,
  input  wire logic                 rd_valid_in,
  input  wire logic [DW-1:0]        rd_data_in
);
  localparam int unsigned CHIP_W = (CHIP_BITS == 0) ? 1 : CHIP_BITS;
  localparam int unsigned LCOL_W = COL_BITS - COL_LSB;
  localparam int unsigned RBC_W  = ROW_BITS + BANK_BITS + LCOL_W;
  localparam int unsigned E_W    = 3 + ADDR_W + SIZE_W + DW + MW;
  localparam int unsigned RQ_W   = $clog2(slp_pkg::REQ_SLOTS + 1);

  if (!((RATE == 1) || (RATE == 2) || (RATE == 4)) || (MAX_BURST < 1) || (MAX_BURST > slp_pkg::MAX_BURST_LIM)
      || (COL_BITS <= COL_LSB) || ((DW % 8) != 0))
  begin : g_bad_cfg
    $error("slp_local_port: unsupported rate, burst limit or geometry");
  end

  logic                 init_q;
  logic [SIZE_W-1:0]    wr_left_q;
  logic [ADDR_W-1:0]    cap_addr_q;
  logic [SIZE_W-1:0]    cap_size_q;
  logic                 cap_apch_q;
  logic [RQ_W-1:0]      req_cnt_q;
  logic [SIZE_W-1:0]    out_left_q;
  logic                 rf_ack_q;
  logic                 rf_pend_q;
  logic [slp_pkg::REFI_W-1:0] refi_q;
  slp_pkg::slp_sr_state_t     sr_q;
  logic                 sr_ack_q;
  logic [NUM_CS-1:0]    sr_chip_q;
  logic [DW-1:0]        rdata_q;
  logic                 rvalid_q;
  logic                 acc;
  logic                 wr_new;
  logic                 new_req;
  logic                 fifo_in_ready;
  logic                 head_valid;
  logic [E_W-1:0]       in_ent;
  logic [E_W-1:0]       head;
  logic                 h_first;
  logic [ADDR_W-1:0]    h_addr;
  logic [CHIP_W+ADDR_W-1:0] h_addr_ext;
  logic [SIZE_W-1:0]    h_size;
  logic                 rf_want;
  logic                 rf_go;
  logic                 pop;

  // Entry layout: first, write, autopch, addr, size, data, mask
  assign wr_new  = (wr_left_q == '0) || local_burst_begin;
  assign acc     = local_ready && (local_write_req || local_read_req);
  assign new_req = acc && (local_read_req || wr_new);
  assign in_ent  = new_req ? {1'b1, local_write_req, local_autopch_req, local_addr, local_size, local_wdata,
                              local_byte_mask}
                           : {1'b0, 1'b1, cap_apch_q, cap_addr_q, cap_size_q, local_wdata, local_byte_mask};

  // Ready waits for init, FIFO space and a free request slot; master holds while low
  assign local_ready = init_q && fifo_in_ready && (req_cnt_q < RQ_W'(slp_pkg::REQ_SLOTS));

  slp_fifo #(
    .W     (E_W),
    .DEPTH (slp_pkg::FIFO_WORDS)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (acc),
    .in_ready  (fifo_in_ready),
    .in_data   (in_ent),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // Head decode into memory-side fields
  assign h_first         = head[E_W-1];
  assign mem_cmd_first   = h_first;
  assign mem_cmd_write   = head[E_W-2];
  assign mem_cmd_autopch = head[E_W-3];
  assign h_addr          = head[E_W-4 -: ADDR_W];
  assign h_size          = head[DW+MW +: SIZE_W];
  assign mem_cmd_size    = (h_size == '0) ? SIZE_W'(1) : h_size;
  assign mem_wr_data     = head[MW +: DW];
  assign memory_data_mask = ~head[MW-1:0];
  assign h_addr_ext      = {{CHIP_W{1'b0}}, h_addr};
  assign mem_cmd_row     = h_addr[RBC_W-1 -: ROW_BITS];
  assign mem_cmd_bank    = h_addr[LCOL_W +: BANK_BITS];
  assign mem_cmd_col     = {h_addr[LCOL_W-1:0], {COL_LSB{1'b0}}};
  assign mem_cmd_chip    = (CHIP_BITS == 0) ? NUM_CS'(1)
                                            : NUM_CS'(1) << h_addr_ext[RBC_W +: CHIP_W];

  // Refresh waits only for init, for a burst already being issued, for the self-refresh sequencer to be idle and for the previous ack cycle to end
  assign rf_want = init_q && (sr_q == slp_pkg::SR_IDLE) && (out_left_q == '0) && !rf_ack_q
                   && (USER_RFSH ? local_refresh_req : rf_pend_q);
  assign rf_go   = rf_want && mem_cmd_ready;
  assign mem_refresh_valid = rf_want;
  assign mem_refresh_chip  = USER_RFSH ? local_refresh_chip : '1;
  assign mem_cmd_valid = head_valid && !rf_want && (sr_q == slp_pkg::SR_IDLE);
  assign pop           = mem_cmd_valid && mem_cmd_ready;

  // Init done tracks the sequencer
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      init_q <= 1'b0;
    else
      init_q <= usr_mode_rdy;
  end
  assign local_init_done = init_q;

  // Write burst beat tracking and first-beat capture
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wr_left_q  <= '0;
      cap_addr_q <= '0;
      cap_size_q <= '0;
      cap_apch_q <= 1'b0;
    end
    else if (acc && local_write_req)
    begin
      if (wr_new)
      begin
        wr_left_q  <= (local_size > SIZE_W'(1)) ? local_size - 1'b1 : '0;
        cap_addr_q <= local_addr;
        cap_size_q <= local_size;
        cap_apch_q <= local_autopch_req;
      end
      else
        wr_left_q <= wr_left_q - 1'b1;
    end
  end

  // Outstanding request count; a request leaves when its first beat issues
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      req_cnt_q <= '0;
    else if (new_req && !(pop && h_first))
      req_cnt_q <= req_cnt_q + 1'b1;
    else if (!new_req && pop && h_first)
      req_cnt_q <= req_cnt_q - 1'b1;
  end

  // Beats left of the write burst now being issued
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      out_left_q <= '0;
    else if (pop && h_first)
      out_left_q <= (mem_cmd_write && (mem_cmd_size > SIZE_W'(1))) ? mem_cmd_size - 1'b1 : '0;
    else if (pop)
      out_left_q <= out_left_q - 1'b1;
  end

  // Refresh acknowledge and the internal interval timer; the gap after each
  // refresh keeps back-to-back requests from merging into one ack
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rf_ack_q  <= 1'b0;
      rf_pend_q <= 1'b0;
      refi_q    <= '0;
    end
    else
    begin
      rf_ack_q <= rf_go;
      if (refi_q == slp_pkg::REFI_W'(slp_pkg::REFI_CYC - 1))
        refi_q <= '0;
      else
        refi_q <= refi_q + 1'b1;
      if (refi_q == slp_pkg::REFI_W'(slp_pkg::REFI_CYC - 1))
        rf_pend_q <= 1'b1;
      else if (rf_go)
        rf_pend_q <= 1'b0;
    end
  end
  assign local_refresh_ack = rf_ack_q;

  // Self-refresh sequencer; entry waits for the issuing burst to finish
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sr_q      <= slp_pkg::SR_IDLE;
      sr_ack_q  <= 1'b0;
      sr_chip_q <= '0;
    end
    else
    begin
      case (sr_q)
        slp_pkg::SR_IDLE:
          if (init_q && local_self_rfsh_req && (out_left_q == '0) && !rf_want)
          begin
            sr_q      <= slp_pkg::SR_ENTER;
            sr_chip_q <= local_self_rfsh_chip;
          end
        slp_pkg::SR_ENTER:
          if (mem_sr_ok)
          begin
            sr_q     <= slp_pkg::SR_IN;
            sr_ack_q <= 1'b1;
          end
        slp_pkg::SR_IN:
          if (!local_self_rfsh_req)
            sr_q <= slp_pkg::SR_EXIT;
        slp_pkg::SR_EXIT:
          if (mem_sr_exit_done)
          begin
            sr_q     <= slp_pkg::SR_IDLE;
            sr_ack_q <= 1'b0;
          end
        default:
          sr_q <= slp_pkg::SR_IDLE;
      endcase
    end
  end
  assign local_self_rfsh_ack = sr_ack_q;
  assign mem_self_rfsh       = (sr_q == slp_pkg::SR_IN) || (sr_q == slp_pkg::SR_EXIT);
  assign mem_self_rfsh_chip  = sr_chip_q;

  // Read return is registered so the user sees flop outputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      rvalid_q <= rd_valid_in;
      if (rd_valid_in)
        rdata_q <= rd_data_in;
    end
  end
  assign local_rdata_valid = rvalid_q;
  assign local_rdata       = rdata_q;

  property p_full_blocks;
    @(posedge core_clk) disable iff (sys_rst)
    (req_cnt_q == RQ_W'(slp_pkg::REQ_SLOTS)) |-> !local_ready;
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("ready high with eight requests held");

  property p_rf_ack_pulse;
    @(posedge core_clk) disable iff (sys_rst)
    rf_go |=> local_refresh_ack ##1 !local_refresh_ack;
  endproperty
  a_rf_ack_pulse: assert property (p_rf_ack_pulse) else $error("refresh ack not a single pulse");

  property p_mask_inv;
    @(posedge core_clk) disable iff (sys_rst)
    mem_cmd_valid |-> ((memory_data_mask ^ head[MW-1:0]) == '1);
  endproperty
  a_mask_inv: assert property (p_mask_inv) else $error("data mask not inverse of byte mask");

  property p_col_low_zero;
    @(posedge core_clk) disable iff (sys_rst)
    mem_cmd_valid |-> (mem_cmd_col[COL_LSB-1:0] == '0);
  endproperty
  a_col_low_zero: assert property (p_col_low_zero) else $error("implied column bits not zero");

  property p_rf_first;
    @(posedge core_clk) disable iff (sys_rst)
    rf_want |-> !pop;
  endproperty
  a_rf_first: assert property (p_rf_first) else $error("command issued over pending refresh");

  property p_init_follow;
    @(posedge core_clk) disable iff (sys_rst)
    ##1 (local_init_done == $past(usr_mode_rdy));
  endproperty
  a_init_follow: assert property (p_init_follow) else $error("init done not tracking ready");

  property p_rvalid;
    @(posedge core_clk) disable iff (sys_rst)
    rd_valid_in |=> local_rdata_valid && (local_rdata == $past(rd_data_in));
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read return lost or altered");

  property p_sr_ack;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(local_self_rfsh_ack) |-> ($past(sr_q) == slp_pkg::SR_ENTER) && $past(mem_sr_ok) && mem_self_rfsh;
  endproperty
  a_sr_ack: assert property (p_sr_ack) else $error("self-refresh ack without entry");

  property p_sr_hold;
    @(posedge core_clk) disable iff (sys_rst)
    (local_self_rfsh_ack && local_self_rfsh_req) |=> local_self_rfsh_ack;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self-refresh ack dropped while held");

  property p_no_accept_early;
    @(posedge core_clk) disable iff (sys_rst)
    !local_init_done |-> !local_ready;
  endproperty
  a_no_accept_early: assert property (p_no_accept_early) else $error("request accepted before init");

endmodule : slp_local_port

`default_nettype wire

// ### sim/slp_mem_model.sv
/*
  Memory-side responder for the local port bench: pops commands with random
  stalls, returns read data and paces self-refresh. Assumes default geometry.
*/
`timescale 1ns/1ps
`default_nettype none
module slp_mem_model (
  input  wire logic        core_clk,
  input  wire logic        stall,
  input  wire logic        mem_cmd_valid,
  input  wire logic        mem_cmd_write,
  input  wire logic [12:0] mem_cmd_row,
  input  wire logic [1:0]  mem_cmd_bank,
  input  wire logic [9:0]  mem_cmd_col,
  input  wire logic        mem_self_rfsh,
  output logic             mem_cmd_ready,
  output logic             mem_sr_ok,
  output logic             mem_sr_exit_done,
  output logic             rd_valid_in,
  output logic [31:0]      rd_data_in
);
  // Quiet start so reset sees clean inputs
  initial
  begin
    {mem_cmd_ready, mem_sr_ok, mem_sr_exit_done, rd_valid_in} = 4'h0;
    rd_data_in = 32'h0;
  end

  // Random stalls exercise holding; idle data toggles so a stale word never looks fresh
  always @(posedge core_clk)
  begin
    mem_cmd_ready    <= !stall && ($urandom % 4 != 0);
    mem_sr_ok        <= ($urandom % 2) != 0;
    mem_sr_exit_done <= mem_self_rfsh && ($urandom % 2 != 0);
    rd_valid_in      <= mem_cmd_valid && mem_cmd_ready && !mem_cmd_write;
    if (mem_cmd_valid && mem_cmd_ready && !mem_cmd_write)
      rd_data_in <= {8'hA5, mem_cmd_row, mem_cmd_bank, mem_cmd_col[9:1]};
    else
      rd_data_in <= ~rd_data_in;
  end
endmodule : slp_mem_model
`default_nettype wire

// ### sim/testbench.sv
/*
  Self-checking bench for the local user port: queued command and read
  expectations, refresh, buffer-full and self-refresh. Assumes default parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk, sys_rst, usr_mode_rdy, stall, rtake_q;
  logic [23:0] local_addr;
  logic [6:0]  local_size, mem_cmd_size;
  logic        local_burst_begin, local_write_req, local_read_req, local_autopch_req;
  logic        local_refresh_req, local_refresh_chip, local_self_rfsh_req, local_self_rfsh_chip;
  logic [31:0] local_wdata, local_rdata, mem_wr_data, rd_data_in;
  logic [3:0]  local_byte_mask, memory_data_mask;
  logic        local_ready, local_rdata_valid, local_refresh_ack, local_self_rfsh_ack, local_init_done;
  logic        mem_cmd_ready, mem_cmd_valid, mem_cmd_first, mem_cmd_write, mem_cmd_autopch;
  logic [12:0] mem_cmd_row;
  logic [1:0]  mem_cmd_bank;
  logic [9:0]  mem_cmd_col;
  logic        mem_refresh_valid, mem_refresh_chip, mem_sr_ok, mem_sr_exit_done;
  logic        mem_self_rfsh, mem_self_rfsh_chip, rd_valid_in, mem_cmd_chip;
  logic [70:0] cq[$];
  logic [31:0] rq[$];
  int          mismatches, tests_run;

  // 40 MHz user clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  slp_local_port slp_local_port_i (
    .core_clk, .sys_rst, .local_addr, .local_size, .local_burst_begin, .local_write_req, .local_read_req,
    .local_wdata, .local_byte_mask, .local_autopch_req, .local_refresh_req, .local_refresh_chip,
    .local_self_rfsh_req, .local_self_rfsh_chip, .local_ready, .local_rdata, .local_rdata_valid,
    .local_refresh_ack, .local_self_rfsh_ack, .local_init_done, .usr_mode_rdy, .mem_cmd_ready,
    .mem_cmd_valid, .mem_cmd_first, .mem_cmd_write, .mem_cmd_autopch, .mem_cmd_chip, .mem_cmd_row,
    .mem_cmd_bank, .mem_cmd_col, .mem_cmd_size, .mem_wr_data, .memory_data_mask, .mem_refresh_valid,
    .mem_refresh_chip, .mem_sr_ok, .mem_sr_exit_done, .mem_self_rfsh, .mem_self_rfsh_chip,
    .rd_valid_in, .rd_data_in
  );

  slp_mem_model slp_mem_model_i (
    .core_clk, .stall, .mem_cmd_valid, .mem_cmd_write, .mem_cmd_row, .mem_cmd_bank, .mem_cmd_col,
    .mem_self_rfsh, .mem_cmd_ready, .mem_sr_ok, .mem_sr_exit_done, .rd_valid_in, .rd_data_in
  );

  task automatic chk(input string n, input logic [70:0] got, input logic [70:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Called at a falling edge; gives up after 400 cycles
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 400; i++)
    begin
      if (s === v)
        return;
      @(negedge core_clk);
    end
    mismatches++;
    $display("BAD wait expected %b seen %b", v, s);
    test_done();
  endtask : wait_for

  // One request held until taken; burst start drops after its first cycle
  task automatic beat(input logic w, input logic bb, input logic [23:0] a, input logic [6:0] n, input logic ap);
    @(negedge core_clk);
    local_write_req   = w;
    local_read_req    = !w;
    local_burst_begin = bb;
    local_addr        = a;
    local_size        = n;
    local_autopch_req = ap;
    local_wdata       = $urandom;
    local_byte_mask   = 4'($urandom);
    #1;
    if (local_ready !== 1'b1)
    begin
      @(negedge core_clk);
      local_burst_begin = 1'b0;
      wait_for(local_ready, 1'b1);
    end
    @(posedge core_clk);
  endtask : beat

  // Later beats carry junk address and size, which must be ignored
  task automatic wr_burst(input logic [23:0] a, input logic [6:0] n, input logic ap);
    for (int i = 0; i < n; i++)
    begin
      beat(1'b1, i == 0, (i == 0) ? a : 24'($urandom), (i == 0) ? n : 7'($urandom_range(1, 64)), ap);
      cq.push_back({1'b1, ap, i == 0, a, 1'b0, n, local_wdata, ~local_byte_mask});
    end
  endtask : wr_burst

  task automatic rd(input logic [23:0] a, input logic [6:0] n, input logic ap);
    beat(1'b0, 1'b1, a, n, ap);
    cq.push_back({1'b0, ap, 1'b1, a, 1'b0, n, 36'h0});
    rq.push_back({8'hA5, a});
  endtask : rd

  task automatic drain;
    @(negedge core_clk);
    local_write_req = 1'b0;
    local_read_req  = 1'b0;
    for (int i = 0; i < 800 && (cq.size() + rq.size()) != 0; i++)
      @(negedge core_clk);
    chk("drained", 71'(cq.size() + rq.size()), 71'h0);
    // A queue that never empties means the port hung; stop here
    if ((cq.size() + rq.size()) != 0)
      test_done();
  endtask : drain

  // Monitor: each popped command and returned word against the oldest note
  always @(posedge core_clk)
  begin
    if (!sys_rst)
    begin
      chk("refresh_ack", local_refresh_ack, rtake_q);
      if (mem_cmd_valid && mem_cmd_ready)
      begin
        chk("cmd", {mem_cmd_write, mem_cmd_autopch, mem_cmd_first, mem_cmd_row, mem_cmd_bank,
            mem_cmd_col, mem_cmd_size, mem_cmd_write ? {mem_wr_data, memory_data_mask} : 36'h0},
            (cq.size() != 0) ? cq.pop_front() : 71'h0);
        chk("chip", mem_cmd_chip, 1'b1);
      end
      if (local_rdata_valid)
        chk("rdata", local_rdata, (rq.size() != 0) ? rq.pop_front() : ~local_rdata);
    end
    rtake_q <= mem_refresh_valid && mem_cmd_ready && !sys_rst;
  end

  // Main sequence
  initial
  begin
    {mismatches, tests_run} = {32'h0, 32'h0};
    {sys_rst, usr_mode_rdy, stall} = 3'h4;
    {local_burst_begin, local_write_req, local_read_req, local_autopch_req} = 4'h0;
    {local_refresh_req, local_refresh_chip, local_self_rfsh_req, local_self_rfsh_chip} = 4'h0;
    {local_addr, local_size, local_wdata, local_byte_mask} = 67'h0;
    void'($urandom(32'h5707));
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("init_early", {local_init_done, local_ready}, 2'b00);
    usr_mode_rdy = 1'b1;
    wait_for(local_init_done, 1'b1);
    // Boundary addresses and sizes, then random back-to-back traffic
    wr_burst(24'hFFFFFF, 7'h02, 1'b1);
    wr_burst(24'h000001, 7'h01, 1'b0);
    rd(24'h800600, 7'h40, 1'b1);
    repeat (24)
      if ($urandom % 2)
        wr_burst(24'($urandom), 7'($urandom_range(1, 4)), 1'($urandom));
      else
        rd(24'($urandom), 7'($urandom_range(1, 64)), 1'($urandom));
    drain();
    // Frozen memory side: eight requests fill the buffer
    stall = 1'b1;
    repeat (8) wr_burst(24'($urandom), 7'h01, 1'b0);
    @(negedge core_clk);
    local_write_req = 1'b0;
    #1;
    chk("ready_full", local_ready, 1'b0);
    // Refresh must overtake the queued writes
    @(negedge core_clk);
    local_refresh_req  = 1'b1;
    local_refresh_chip = 1'b1;
    wait_for(mem_refresh_valid, 1'b1);
    chk("rfsh_first", {mem_cmd_valid, mem_refresh_chip}, 2'b01);
    stall = 1'b0;
    wait_for(local_refresh_ack, 1'b1);
    chk("rfsh_order", 71'(cq.size()), 71'h8);
    local_refresh_req = 1'b0;
    drain();
    // Self-refresh entry, hold and exit
    local_self_rfsh_chip = 1'b1;
    local_self_rfsh_req  = 1'b1;
    wait_for(local_self_rfsh_ack, 1'b1);
    chk("sr_in", {mem_self_rfsh, mem_self_rfsh_chip}, 2'b11);
    repeat (6) @(negedge core_clk);
    chk("sr_hold", local_self_rfsh_ack, 1'b1);
    local_self_rfsh_req = 1'b0;
    wait_for(local_self_rfsh_ack, 1'b0);
    chk("sr_out", mem_self_rfsh, 1'b0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
